//--- include/prog_entry_pkg.sv
package prog_entry_pkg;

    // Address space of the program counter
    localparam logic [13:0] PC_RESET = 14'h0000;
    localparam logic [13:0] USER_TOP_SMALL = 14'h0fff;
    localparam logic [13:0] USER_TOP_LARGE = 14'h1fff;
    localparam logic [13:0] CFG_BASE = 14'h2000;
    localparam logic [13:0] CFG_TOP = 14'h3fff;
    localparam logic [13:0] ID_FIRST = 14'h2000;
    localparam logic [13:0] ID_LAST = 14'h2003;
    localparam logic [13:0] CFG_USE_FIRST = 14'h2007;
    localparam logic [13:0] CFG_USE_LAST = 14'h2009;
    localparam logic [13:0] CALIB_ADDR = 14'h2009;

    // Serial framing
    localparam int CMD_BITS = 6;
    localparam int DATA_CYCLES = 16;
    localparam int WORD_BITS = 14;
    localparam logic [4:0] CNT_CMD_LAST = 5'h05;
    localparam logic [4:0] CNT_BIT_FIRST = 5'h01;
    localparam logic [4:0] CNT_BIT_LAST = 5'h0e;
    localparam logic [4:0] CNT_STOP = 5'h0f;

    // Oscillator codes that require high-voltage-first entry
    localparam logic [2:0] OSC_INTERNAL_A = 3'h4;
    localparam logic [2:0] OSC_INTERNAL_B = 3'h5;

    // Command codes, sent least significant bit first
    localparam logic [5:0] CMD_LOAD_CFG = 6'h00;
    localparam logic [5:0] CMD_LOAD_PROG = 6'h02;
    localparam logic [5:0] CMD_LOAD_DATA = 6'h03;
    localparam logic [5:0] CMD_READ_PROG = 6'h04;
    localparam logic [5:0] CMD_READ_DATA = 6'h05;
    localparam logic [5:0] CMD_INCREMENT = 6'h06;
    localparam logic [5:0] CMD_BEGIN_PROG = 6'h08;
    localparam logic [5:0] CMD_ERASE_PROG = 6'h09;
    localparam logic [5:0] CMD_END_PROG = 6'h0a;
    localparam logic [5:0] CMD_ERASE_DATA = 6'h0b;

    // Serial engine phases
    typedef enum logic [0:0] {S_CMD, S_DATA} serial_state_t;

endpackage

//--- verilog/pin_sync3.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Three-stage pin synchroniser; a change counts once stages two and three agree
module pin_sync3 #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Pins and filtered levels
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    genvar b;
    generate
        for (b = 0; b < WIDTH; b = b + 1)
        begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            // First stage feeds only the second
            always_ff @(posedge clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    lvl_reg <= 1'b0;
                end
                else
                begin
                    s1_reg <= pin_i[b];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg)
                        lvl_reg <= s3_reg;
                end
            end
            assign level_o[b] = lvl_reg;
        end
    endgenerate

endmodule

//--- verilog/prog_mode_entry_address_counter.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module prog_mode_entry_address_counter #(
    parameter bit LARGE_MEMORY = 1'b1
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    // Mode select and entry pins
    input wire logic MASTER_CLEAR_PIN_HV_I,
    input wire logic MASTER_CLEAR_PIN_VDD_I,
    input wire logic LOW_VOLT_ENTRY_PIN_I,
    // Configuration bits from the stored configuration word
    input wire logic LOW_VOLT_PROG_ENABLE_I,
    input wire logic CODE_PROTECT_I,
    // Serial link
    input wire logic PROG_SERIAL_CLOCK_I,
    input wire logic PROG_SERIAL_DATA_I,
    output logic PROG_SERIAL_DATA_O,
    output logic PROG_SERIAL_DATA_OE_O,
    // Device state
    output logic PROG_MODE_O,
    output logic LOGIC_RESET_O,
    output logic IO_HIZ_O,
    output logic ENTRY_PIN_DEDICATED_O,
    // Memory array
    output logic [13:0] MEM_ADDR_O,
    output logic MEM_DATA_SPACE_O,
    input wire logic [13:0] MEM_RDATA_I,
    output logic [13:0] MEM_WDATA_O,
    output logic MEM_WR_O,
    output logic ERASE_PROG_O,
    output logic ERASE_ID_O,
    output logic ERASE_CALIB_O,
    output logic ERASE_DATA_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [4:0] pins_lvl;
    logic hv_s, vdd_s, lve_s, sclk_s, sdat_s;

    pin_sync3 #(.WIDTH(5)) u_sync (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .pin_i({MASTER_CLEAR_PIN_HV_I, MASTER_CLEAR_PIN_VDD_I, LOW_VOLT_ENTRY_PIN_I,
                PROG_SERIAL_CLOCK_I, PROG_SERIAL_DATA_I}),
        .level_o(pins_lvl)
    );
    assign {hv_s, vdd_s, lve_s, sclk_s, sdat_s} = pins_lvl;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic in_mode_reg;
    logic sclk_prev_reg;
    logic dedicated_reg;
    prog_entry_pkg::serial_state_t state_reg;
    prog_entry_pkg::serial_state_t state_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic [5:0] cmd_reg;
    logic [5:0] cmd_next;
    logic [13:0] pc_reg;
    logic [13:0] pc_next;
    logic [13:0] rd_reg;
    logic [13:0] rd_next;
    logic [13:0] wr_reg;
    logic [13:0] wr_next;
    logic space_reg;
    logic space_next;
    logic oe_reg;
    logic oe_next;
    logic dout_reg;
    logic dout_next;
    logic [4:0] pulse_reg;
    logic [4:0] pulse_next;

    ////////////////////////////////////////////////////////////////////////////
    // Mode entry decode
    wire lv_entry = LOW_VOLT_PROG_ENABLE_I & lve_s & vdd_s;
    wire entry_req = hv_s | lv_entry;
    wire entering = entry_req & ~in_mode_reg;
    wire clk_rise = in_mode_reg & sclk_s & ~sclk_prev_reg;
    wire clk_fall = in_mode_reg & ~sclk_s & sclk_prev_reg;

    // Command decode
    wire [5:0] cmd_word = {sdat_s, cmd_reg[5:1]};
    wire cmd_done = clk_fall && (cnt_reg == prog_entry_pkg::CNT_CMD_LAST);
    wire word_is_load = (cmd_word == prog_entry_pkg::CMD_LOAD_CFG)
        || (cmd_word == prog_entry_pkg::CMD_LOAD_PROG)
        || (cmd_word == prog_entry_pkg::CMD_LOAD_DATA);
    wire word_is_read = (cmd_word == prog_entry_pkg::CMD_READ_PROG)
        || (cmd_word == prog_entry_pkg::CMD_READ_DATA);
    wire word_is_data_space = (cmd_word == prog_entry_pkg::CMD_LOAD_DATA)
        || (cmd_word == prog_entry_pkg::CMD_READ_DATA);
    wire frame_is_load = (cmd_reg == prog_entry_pkg::CMD_LOAD_CFG)
        || (cmd_reg == prog_entry_pkg::CMD_LOAD_PROG)
        || (cmd_reg == prog_entry_pkg::CMD_LOAD_DATA);
    wire frame_is_read = (cmd_reg == prog_entry_pkg::CMD_READ_PROG)
        || (cmd_reg == prog_entry_pkg::CMD_READ_DATA);
    wire in_bits = (cnt_reg >= prog_entry_pkg::CNT_BIT_FIRST)
        && (cnt_reg <= prog_entry_pkg::CNT_BIT_LAST);

    // Address map decode
    wire [13:0] user_top = LARGE_MEMORY ? prog_entry_pkg::USER_TOP_LARGE
        : prog_entry_pkg::USER_TOP_SMALL;
    wire in_user = ~pc_reg[13] && (pc_reg <= user_top);
    wire in_id = (pc_reg >= prog_entry_pkg::ID_FIRST) && (pc_reg <= prog_entry_pkg::ID_LAST);
    wire in_cfg_use = (pc_reg >= prog_entry_pkg::CFG_USE_FIRST)
        && (pc_reg <= prog_entry_pkg::CFG_USE_LAST);
    wire usable = space_reg | in_user | in_id | in_cfg_use;
    wire protect_hit = in_user & ~space_reg & CODE_PROTECT_I;
    wire [13:0] rd_value = (usable && !protect_hit) ? MEM_RDATA_I : 14'h0000;
    wire [13:0] pc_inc = {pc_reg[13], 13'(pc_reg[12:0] + 13'h0001)};

    ////////////////////////////////////////////////////////////////////////////
    // Serial engine and address counter next state
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        cmd_next = cmd_reg;
        pc_next = pc_reg;
        rd_next = rd_reg;
        wr_next = wr_reg;
        space_next = space_reg;
        oe_next = oe_reg;
        dout_next = dout_reg;
        pulse_next = 5'h00;
        if (!in_mode_reg)
        begin
            state_next = prog_entry_pkg::S_CMD;
            cnt_next = 5'h00;
            pc_next = prog_entry_pkg::PC_RESET;
            oe_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                prog_entry_pkg::S_CMD:
                begin
                    if (clk_fall)
                    begin
                        cmd_next = cmd_word;
                        cnt_next = 5'(cnt_reg + 5'h01);
                    end
                    if (cmd_done)
                    begin
                        cnt_next = 5'h00;
                        if (cmd_word == prog_entry_pkg::CMD_INCREMENT)
                            pc_next = pc_inc;
                        else if (cmd_word == prog_entry_pkg::CMD_BEGIN_PROG)
                            pulse_next[0] = usable;
                        else if (cmd_word == prog_entry_pkg::CMD_ERASE_PROG)
                        begin
                            pulse_next[1] = 1'b1;
                            pulse_next[2] = pc_reg[13];
                            pulse_next[3] = (pc_reg == prog_entry_pkg::CALIB_ADDR);
                        end
                        else if (cmd_word == prog_entry_pkg::CMD_ERASE_DATA)
                            pulse_next[4] = 1'b1;
                        else if (word_is_load || word_is_read)
                        begin
                            state_next = prog_entry_pkg::S_DATA;
                            space_next = word_is_data_space;
                        end
                    end
                end
                prog_entry_pkg::S_DATA:
                begin
                    if (clk_rise && frame_is_read)
                    begin
                        if (cnt_reg == 5'h00)
                            rd_next = rd_value;
                        else if (in_bits)
                        begin
                            oe_next = 1'b1;
                            dout_next = rd_reg[0];
                            rd_next = {1'b0, rd_reg[13:1]};
                        end
                        else
                            oe_next = 1'b0;
                    end
                    if (clk_fall)
                    begin
                        cnt_next = 5'(cnt_reg + 5'h01);
                        if (frame_is_load && in_bits)
                            wr_next = {sdat_s, wr_reg[13:1]};
                        if (cnt_reg == prog_entry_pkg::CNT_STOP)
                        begin
                            state_next = prog_entry_pkg::S_CMD;
                            cnt_next = 5'h00;
                            oe_next = 1'b0;
                            if (cmd_reg == prog_entry_pkg::CMD_LOAD_CFG)
                                pc_next = prog_entry_pkg::CFG_BASE;
                        end
                    end
                end
                default:
                    state_next = prog_entry_pkg::S_CMD;
            endcase
        end
    end

    // Mode and edge tracking
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            in_mode_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            dedicated_reg <= 1'b0;
        end
        else
        begin
            in_mode_reg <= entry_req;
            sclk_prev_reg <= sclk_s;
            dedicated_reg <= LOW_VOLT_PROG_ENABLE_I;
        end
    end

    // Serial engine state
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_reg <= prog_entry_pkg::S_CMD;
            cnt_reg <= 5'h00;
            cmd_reg <= 6'h00;
            rd_reg <= 14'h0000;
            oe_reg <= 1'b0;
            dout_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cmd_reg <= cmd_next;
            rd_reg <= rd_next;
            oe_reg <= oe_next;
            dout_reg <= dout_next;
        end
    end

    // Address counter, write latch and memory strobes
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pc_reg <= prog_entry_pkg::PC_RESET;
            wr_reg <= 14'h0000;
            space_reg <= 1'b0;
            pulse_reg <= 5'h00;
        end
        else
        begin
            pc_reg <= pc_next;
            wr_reg <= wr_next;
            space_reg <= space_next;
            pulse_reg <= pulse_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign PROG_SERIAL_DATA_O = dout_reg;
    assign PROG_SERIAL_DATA_OE_O = oe_reg;
    assign PROG_MODE_O = in_mode_reg;
    assign LOGIC_RESET_O = in_mode_reg;
    assign IO_HIZ_O = in_mode_reg;
    assign ENTRY_PIN_DEDICATED_O = dedicated_reg;
    assign MEM_ADDR_O = pc_reg;
    assign MEM_DATA_SPACE_O = space_reg;
    assign MEM_WDATA_O = wr_reg;
    assign {ERASE_DATA_O, ERASE_CALIB_O, ERASE_ID_O, ERASE_PROG_O, MEM_WR_O} = pulse_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    wire inc_now = in_mode_reg && cmd_done && (cmd_word == prog_entry_pkg::CMD_INCREMENT);
    a_user_wrap: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        inc_now && (pc_reg == prog_entry_pkg::USER_TOP_LARGE) |=> pc_reg == 14'h0000)
        else $error("user space counter did not wrap to zero");
    a_cfg_wrap: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        inc_now && (pc_reg == prog_entry_pkg::CFG_TOP) |=> pc_reg == prog_entry_pkg::CFG_BASE)
        else $error("config space counter did not wrap to base");
    a_top_sticky: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        in_mode_reg && entry_req && pc_reg[13] |=> pc_reg[13])
        else $error("config space bit cleared inside mode");
    a_cfg_load: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        in_mode_reg && entry_req && state_reg == prog_entry_pkg::S_DATA && clk_fall
        && cnt_reg == prog_entry_pkg::CNT_STOP && cmd_reg == prog_entry_pkg::CMD_LOAD_CFG
        |=> pc_reg == prog_entry_pkg::CFG_BASE)
        else $error("load config did not point counter at base");
    a_entry_clear: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $rose(in_mode_reg) |-> pc_reg == 14'h0000 && LOGIC_RESET_O && IO_HIZ_O)
        else $error("mode entry left counter or I/O state wrong");
    a_lv_gate: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        entering && !hv_s |-> LOW_VOLT_PROG_ENABLE_I && lve_s && vdd_s)
        else $error("low-voltage entry taken while disabled");
    a_calib_keep: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ERASE_CALIB_O |-> ERASE_PROG_O && $past(pc_reg) == prog_entry_pkg::CALIB_ADDR)
        else $error("calibration erased from wrong address");
    a_idle_quiet: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        !in_mode_reg ##1 !in_mode_reg |-> pulse_reg == 5'h00 && !oe_reg && pc_reg == 14'h0000)
        else $error("activity outside programming mode");
    a_read_drive: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        in_mode_reg && entry_req && state_reg == prog_entry_pkg::S_DATA && frame_is_read
        && clk_rise && cnt_reg == prog_entry_pkg::CNT_BIT_FIRST
        |=> PROG_SERIAL_DATA_OE_O && PROG_SERIAL_DATA_O == $past(rd_reg[0]))
        else $error("read bit not driven in second data cycle");
    a_reserved_wr: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
        MEM_WR_O |-> $past(usable))
        else $error("write strobe to reserved or absent location");

endmodule

//--- verif/prog_host_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Programmer model: mode pins and serial link; the link clock idles low between frames
module prog_host_model #(
    parameter realtime HALF = 62.5,
    parameter realtime GAP = 250.0
) (
    // Pins toward the device
    output logic sclk_o,
    output logic sdat_o,
    output logic sdat_oe_o,
    output logic hv_o,
    output logic vdd_o,
    output logic entry_o,
    // Resolved data line
    input wire logic sdat_i
);
    // Everything low and driven at start
    initial
    begin
        {sclk_o, sdat_o, hv_o, vdd_o, entry_o} = 5'h00;
        sdat_oe_o = 1'b1;
    end

    // One link cycle: data set on the rise, taken by the device on the fall
    task automatic pulse(input logic b, output logic seen);
        sclk_o = 1'b1;
        sdat_o = b;
        #(HALF);
        seen = sdat_i;
        sclk_o = 1'b0;
        #(HALF);
    endtask

    // Command of six cycles, lowest bit first
    task automatic cmd(input logic [5:0] code);
        logic s;
        sdat_oe_o = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            pulse(code[i], s);
        end
        sdat_o = 1'b0;
        #(GAP);
    endtask

    // Data frame of sixteen cycles: start, fourteen bits, stop
    task automatic frame(input logic [5:0] code, input logic drive, input logic [13:0] w,
                         output logic [13:0] r);
        logic [15:0] v;
        logic [15:0] got;
        cmd(code);
        v = {1'b0, w, 1'b0};
        sdat_oe_o = drive;
        for (int i = 0; i < 16; i++)
        begin
            pulse(v[i], got[i]);
        end
        r = got[14:1];
        sdat_o = 1'b0;
        #(GAP);
    endtask

    // Entry with serial lines held low; high voltage suits any oscillator setting
    task automatic enter(input logic low_volt);
        sclk_o = 1'b0;
        sdat_o = 1'b0;
        entry_o = low_volt;
        #(GAP);
        vdd_o = low_volt;
        hv_o = ~low_volt;
        #(GAP);
    endtask

    // Drop every entry condition
    task automatic leave();
        {hv_o, vdd_o, entry_o} = 3'h0;
        #(GAP);
    endtask
endmodule

//--- verif/prog_mode_entry_address_counter_tb_top.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Bench: programmer model on the link, array stand-in, sequenced checks
module prog_mode_entry_address_counter_tb_top;
    logic clk;
    logic rst_n;
    logic lvp_en;
    logic cp;
    logic float_bit = 1'b0;
    logic [13:0] rdata = 14'h0000;
    logic [13:0] r;
    logic sdo_d, soe_d, pmode, lreset, hiz, dedic, dspace, mwr, e_prog, e_id, e_cal, e_data;
    logic [13:0] addr;
    logic [13:0] wdata;
    wire logic sclk, sdo_h, soe_h, hv, vdd, entry;
    // Released line shows a pattern that changes every cycle
    wire logic sdat = soe_d ? sdo_d : (soe_h ? sdo_h : float_bit);
    int bad_count = 0, n_compared = 0, n_wr = 0, n_ep = 0, n_id = 0, n_cal = 0, n_ed = 0;

    prog_mode_entry_address_counter #(.LARGE_MEMORY(1'b1)) u_prog_mode_entry_address_counter (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .MASTER_CLEAR_PIN_HV_I(hv),
        .MASTER_CLEAR_PIN_VDD_I(vdd), .LOW_VOLT_ENTRY_PIN_I(entry),
        .LOW_VOLT_PROG_ENABLE_I(lvp_en), .CODE_PROTECT_I(cp), .PROG_SERIAL_CLOCK_I(sclk),
        .PROG_SERIAL_DATA_I(sdat), .PROG_SERIAL_DATA_O(sdo_d), .PROG_SERIAL_DATA_OE_O(soe_d),
        .PROG_MODE_O(pmode), .LOGIC_RESET_O(lreset), .IO_HIZ_O(hiz),
        .ENTRY_PIN_DEDICATED_O(dedic), .MEM_ADDR_O(addr), .MEM_DATA_SPACE_O(dspace),
        .MEM_RDATA_I(rdata), .MEM_WDATA_O(wdata), .MEM_WR_O(mwr), .ERASE_PROG_O(e_prog),
        .ERASE_ID_O(e_id), .ERASE_CALIB_O(e_cal), .ERASE_DATA_O(e_data));

    prog_host_model u_prog_host_model (
        .sclk_o(sclk), .sdat_o(sdo_h), .sdat_oe_o(soe_h), .hv_o(hv), .vdd_o(vdd),
        .entry_o(entry), .sdat_i(sdat));

    // Core clock, 8 ns
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Array stand-in and pulse counters
    always @(posedge clk)
    begin
        float_bit <= ~float_bit;
        rdata <= addr ^ 14'h2a5a;
        n_wr <= n_wr + int'(mwr === 1'b1);
        n_ep <= n_ep + int'(e_prog === 1'b1);
        n_id <= n_id + int'(e_id === 1'b1);
        n_cal <= n_cal + int'(e_cal === 1'b1);
        n_ed <= n_ed + int'(e_data === 1'b1);
    end

    // Compare and count
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("counts: %0d compared, %0d mismatched", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic incs(input int n);
        for (int i = 0; i < n; i++)
        begin
            u_prog_host_model.cmd(prog_entry_pkg::CMD_INCREMENT);
        end
    endtask

    // Hang guard
    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        $display("unexpected at %0t: seen 0x0 expected 0x1 (timeout)", $time);
        finish_test();
    end

    // Main sequence
    initial
    begin
        {rst_n, lvp_en, cp} = 3'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1.3;
        // Serial traffic outside the mode
        u_prog_host_model.frame(prog_entry_pkg::CMD_LOAD_PROG, 1'b1, 14'h0abc, r);
        incs(1);
        u_prog_host_model.cmd(prog_entry_pkg::CMD_BEGIN_PROG);
        check({pmode, addr, wdata[3:0]}, 19'h0);
        check(n_wr, 0);
        $display("test idle done");
        // High-voltage entry, counting and an unknown command
        u_prog_host_model.enter(1'b0);
        check({pmode, lreset, hiz, addr}, {3'h7, 14'h0000});
        incs(2);
        check(addr, 14'h0002);
        u_prog_host_model.cmd(6'h18);
        check(addr, 14'h0002);
        $display("test entry done");
        // Load, write, read and protection in user space
        u_prog_host_model.frame(prog_entry_pkg::CMD_LOAD_PROG, 1'b1, 14'h1234, r);
        check(wdata, 14'h1234);
        u_prog_host_model.cmd(prog_entry_pkg::CMD_BEGIN_PROG);
        check(n_wr, 1);
        u_prog_host_model.frame(prog_entry_pkg::CMD_READ_PROG, 1'b0, 14'h0, r);
        check(r, 14'h0002 ^ 14'h2a5a);
        check(soe_d, 1'b0);
        u_prog_host_model.cmd(prog_entry_pkg::CMD_ERASE_PROG);
        check({n_ep[3:0], n_id[3:0], n_cal[3:0]}, 12'h100);
        u_prog_host_model.frame(prog_entry_pkg::CMD_LOAD_DATA, 1'b1, 14'h0055, r);
        u_prog_host_model.cmd(prog_entry_pkg::CMD_ERASE_DATA);
        check({dspace, n_ed[3:0]}, 5'h11);
        u_prog_host_model.frame(prog_entry_pkg::CMD_READ_DATA, 1'b0, 14'h0, r);
        check({dspace, r}, {1'b1, 14'h0002 ^ 14'h2a5a});
        @(posedge clk) cp <= 1'b1;
        #1.3;
        u_prog_host_model.frame(prog_entry_pkg::CMD_READ_PROG, 1'b0, 14'h0, r);
        check(r, 14'h0000);
        $display("test user done");
        // Configuration space: IDs, reserved places, calibration erase, sticky top bit
        u_prog_host_model.frame(prog_entry_pkg::CMD_LOAD_CFG, 1'b1, 14'h3fff, r);
        check(addr, 14'h2000);
        u_prog_host_model.frame(prog_entry_pkg::CMD_READ_PROG, 1'b0, 14'h0, r);
        check(r, 14'h2000 ^ 14'h2a5a);
        u_prog_host_model.frame(prog_entry_pkg::CMD_LOAD_PROG, 1'b1, 14'h007f, r);
        u_prog_host_model.cmd(prog_entry_pkg::CMD_BEGIN_PROG);
        check(n_wr, 2);
        u_prog_host_model.cmd(prog_entry_pkg::CMD_ERASE_PROG);
        check({n_ep[3:0], n_id[3:0], n_cal[3:0]}, 12'h210);
        incs(4);
        u_prog_host_model.frame(prog_entry_pkg::CMD_READ_PROG, 1'b0, 14'h0, r);
        check({addr, r}, {14'h2004, 14'h0000});
        u_prog_host_model.cmd(prog_entry_pkg::CMD_BEGIN_PROG);
        check(n_wr, 2);
        incs(3);
        u_prog_host_model.frame(prog_entry_pkg::CMD_READ_PROG, 1'b0, 14'h0, r);
        check(r, 14'h2007 ^ 14'h2a5a);
        incs(2);
        u_prog_host_model.cmd(prog_entry_pkg::CMD_ERASE_PROG);
        check({n_ep[3:0], n_id[3:0], n_cal[3:0]}, 12'h321);
        check(addr, 14'h2009);
        u_prog_host_model.leave();
        check({pmode, addr}, 15'h0);
        $display("test config done");
        // Low-voltage entry enabled, then refused once the enable bit is cleared
        @(posedge clk) lvp_en <= 1'b1;
        repeat (3) @(posedge clk);
        #1.3;
        check(dedic, 1'b1);
        u_prog_host_model.enter(1'b1);
        check({pmode, addr}, 15'h4000);
        u_prog_host_model.leave();
        @(posedge clk) lvp_en <= 1'b0;
        repeat (3) @(posedge clk);
        #1.3;
        u_prog_host_model.enter(1'b1);
        check({pmode, dedic}, 2'h0);
        u_prog_host_model.leave();
        $display("test low_volt done");
        finish_test();
    end
endmodule
